/* File: hdl/fsp_flash_regs.svh */
// register offsets, field positions, command codes and timing counts
`ifndef FSP_FLASH_REGS_SVH
`define FSP_FLASH_REGS_SVH

// register addresses in the core's access space
`define FSP_OFS_PTR_LOW 6'h1E
`define FSP_OFS_PTR_HIGH 6'h1F
`define FSP_OFS_CTRL 6'h37
`define FSP_CTRL_RESET 4'h0

// control field positions
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCKSET 3

// legal command codes of the control low nibble
`define FSP_CMD_FILL 4'h1
`define FSP_CMD_ERASE 4'h3
`define FSP_CMD_WRITE 4'h5
`define FSP_CMD_LOCK 4'h9

// enable windows in cycles after the control write
`define FSP_WINDOW_STORE 3'h4
`define FSP_WINDOW_LOAD 3'h3

// memory map in words and pages
`define FSP_BOOT_START 13'h1E00
`define FSP_APP_VECTOR 13'h0000
`define FSP_PAGE_WORDS 7'h40
`define FSP_LOCK_READ_PTR 14'h0001
`define FSP_FUSE_READ_PTR 14'h0000

// lock field positions: boot pair, application pair, general pair
`define FSP_LK_BOOT_READ 5
`define FSP_LK_BOOT_WRITE 4
`define FSP_LK_APP_READ 3
`define FSP_LK_APP_WRITE 2
`define FSP_LK_RW 0
`define FSP_FUSE_BOOTVEC 0
`define FSP_LOCK_ERASED 6'h3F

// self-timed operation lengths
`define FSP_CLK_PERIOD_NS 20
`define FSP_ERASE_TIME_NS 20000
`define FSP_WRITE_TIME_NS 20000
`define FSP_LOCK_TIME_NS 20
`define FSP_ERASE_CYCLES ((`FSP_ERASE_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_WRITE_CYCLES ((`FSP_WRITE_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_LOCK_CYCLES ((`FSP_LOCK_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

/* File: hdl/fsp_pkg.sv */
// types shared by the flash self-programming modules
`default_nettype none
package fsp_pkg;
    // operation in flight while the core is halted
    typedef enum logic [1:0] {
        FSP_OP_IDLE = 2'b00,
        FSP_OP_ERASE = 2'b01,
        FSP_OP_WRITE = 2'b10,
        FSP_OP_LOCK = 2'b11
    } fsp_op_e;
    typedef logic [10:0] fsp_count_t;
    typedef logic [5:0] fsp_word_idx_t;
endpackage : fsp_pkg
`default_nettype wire

/* File: hdl/fsp_core_if.sv */
// internal carrier between controller, page buffer and operation timer
`default_nettype none
interface fsp_core_if;
    import fsp_pkg::*;
    logic buf_we;
    fsp_word_idx_t buf_widx;
    logic [15:0] buf_wdata;
    fsp_word_idx_t buf_ridx;
    logic [15:0] buf_rdata;
    logic tmr_start;
    fsp_count_t tmr_len;
    logic tmr_busy;
    logic tmr_done;
    fsp_count_t tmr_count;
    modport ctrl (output buf_we, buf_widx, buf_wdata, buf_ridx, tmr_start, tmr_len,
                  input buf_rdata, tmr_busy, tmr_done, tmr_count);
    modport pbuf (input buf_we, buf_widx, buf_wdata, buf_ridx, output buf_rdata);
    modport tmr (input tmr_start, tmr_len, output tmr_busy, tmr_done, tmr_count);
endinterface : fsp_core_if
`default_nettype wire

/* File: hdl/fsp_page_buffer.sv */
// temporary page buffer of 64 words, random-order fill
`default_nettype none
module fsp_page_buffer
    import fsp_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // carrier
    fsp_core_if.pbuf bus
);
    logic [15:0] mem [64];

    // no reset on the array: contents are only meaningful after a fill
    always_ff @(posedge i_core_clk) begin
        if (bus.buf_we) begin
            mem[bus.buf_widx] <= bus.buf_wdata;
        end
    end

    // asynchronous read; the controller registers it toward the array
    assign bus.buf_rdata = mem[bus.buf_ridx];
endmodule : fsp_page_buffer
`default_nettype wire

/* File: hdl/fsp_op_timer.sv */
// self-timing counter for erase, write and lock-set operations
`default_nettype none
module fsp_op_timer
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // carrier
    fsp_core_if.tmr bus
);
    logic busy;
    logic done;
    fsp_count_t count;
    fsp_count_t len;
    logic next_busy;
    logic next_done;
    fsp_count_t next_count;
    fsp_count_t next_len;

    // count from start until length reached, then a one-cycle done
    always_comb begin
        next_busy = busy;
        next_done = 1'b0;
        next_count = count;
        next_len = len;
        if (bus.tmr_start && !busy) begin
            next_busy = 1'b1;
            next_count = '0;
            next_len = bus.tmr_len;
        end else if (busy) begin
            if (count >= 11'(len - 11'h001)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = 11'(count + 11'h001);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy <= 1'b0;
            done <= 1'b0;
            count <= '0;
            len <= '0;
        end else begin
            busy <= next_busy;
            done <= next_done;
            count <= next_count;
            len <= next_len;
        end
    end

    assign bus.tmr_busy = busy;
    assign bus.tmr_done = done;
    assign bus.tmr_count = count;
endmodule : fsp_op_timer
`default_nettype wire

/* File: hdl/fsp_flash_self_program.sv */
// flash self-programming controller: control register, pointer, locks and fuses
`include "fsp_flash_regs.svh"
`default_nettype none
// Contract
// R1 - reset vector is 0x1E00 with boot vector fuse at 0, else 0x0000
// R2 - the core has no path that alters any fuse
// R3 - with read/write lock programmed, boot vector fuse changes only after chip erase
// R4 - boot code may store to and load from the whole flash, boot section included
// R5 - general lock bits never gate self-programming stores or loads
// R6 - flash changes a whole page of 64 words: erase, buffer fill, write
// R7 - core is stalled through erase and write, then enable clears
// R8 - code 1001 plus store programs boot locks where data low bits 5..2 are zero
// R9 - code 0011 plus store erases page at pointer bits 13..7
// R10 - code 0001 plus store fills buffer word at pointer bits 6..1
// R11 - code 0101 plus store writes buffer into page at pointer bits 13..7
// R12 - after page write the pointer addresses the first word of the next page
// R13 - pointer bits 15..14 ignored; bit 0 ignored by stores
// R14 - lock set ignores pointer and data high register
// R15 - enable opens a four-cycle store window, clears on use or expiry
// R16 - command bits clear on completion or after four idle cycles
// R17 - illegal codes and writes while a command is set are ignored
// R18 - busy eeprom write blocks control writes, stores and readback
// R19 - pointer 0001 with lock command: load within three cycles returns lock bits
// R20 - pointer 0000 with lock command: load within three cycles returns fuse bits
// R21 - programmed fuse and lock bits read back as zero
// R22 - lock bits only get programmed; only chip erase returns them to one
// R23 - stores take effect only when executed from the boot section
// R24 - boot lock pairs restrict stores and cross-section loads per section
// R25 - erase and write are self-timed; core resumes when the operation ends
module fsp_flash_self_program
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // register access from the core
    input wire logic [5:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // instruction strobes and operands from the core
    input wire logic i_store_instr,
    input wire logic i_load_instr,
    input wire logic [12:0] i_pc,
    input wire logic [7:0] i_data_low,
    input wire logic [7:0] i_data_high,
    input wire logic i_eeprom_busy,
    output logic o_stall,
    output logic o_load_valid,
    output logic [7:0] o_load_data,
    output logic o_load_deny,
    output logic [12:0] o_reset_vector,
    // flash array side
    output logic o_flash_erase,
    output logic [6:0] o_flash_page,
    output logic o_flash_prog_valid,
    output logic [12:0] o_flash_prog_addr,
    output logic [15:0] o_flash_prog_data,
    // nonvolatile state and external programming pins
    input wire logic [5:0] i_lock_init,
    input wire logic [5:0] i_fuse_init,
    input wire logic i_chip_erase,
    input wire logic i_ext_fuse_wr,
    input wire logic [5:0] i_ext_fuse_val
);
    fsp_core_if core_bus();

    fsp_page_buffer u_buf (
        .i_core_clk(i_core_clk),
        .bus(core_bus.pbuf)
    );

    fsp_op_timer u_tmr (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .bus(core_bus.tmr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic in_boot(input logic [12:0] word_addr);
        in_boot = (word_addr >= `FSP_BOOT_START);
    endfunction : in_boot

    function automatic logic is_legal(input logic [3:0] code);
        is_legal = (code == `FSP_CMD_FILL) || (code == `FSP_CMD_ERASE) ||
                   (code == `FSP_CMD_WRITE) || (code == `FSP_CMD_LOCK);
    endfunction : is_legal

    // only the boot pairs count; general lock bits are deliberately not consulted
    function automatic logic write_ok(input logic [6:0] page, input logic [5:0] lk);
        write_ok = in_boot({page, 6'h00}) ? lk[`FSP_LK_BOOT_WRITE] : lk[`FSP_LK_APP_WRITE];
    endfunction : write_ok

    function automatic logic read_ok(input logic [12:0] pc, input logic [12:0] target,
                                     input logic [5:0] lk);
        logic from_boot;
        logic to_boot;
        from_boot = in_boot(pc);
        to_boot = in_boot(target);
        if (from_boot && !to_boot) begin
            read_ok = lk[`FSP_LK_APP_READ];
        end else if (!from_boot && to_boot) begin
            read_ok = lk[`FSP_LK_BOOT_READ];
        end else begin
            read_ok = 1'b1;
        end
    endfunction : read_ok

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the external programming side

    logic [13:0] pin_meta;
    logic [13:0] pin_sync;
    logic [5:0] lock_init_s;
    logic [5:0] fuse_init_s;
    logic erase_s;
    logic fuse_wr_s;
    logic [5:0] fuse_val_s;
    logic [5:0] init_meta;
    logic [5:0] init_sync;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_meta <= '0;
            pin_sync <= '0;
            init_meta <= 6'h3F;
            init_sync <= 6'h3F;
        end else begin
            pin_meta <= {i_chip_erase, i_ext_fuse_wr, i_ext_fuse_val, i_lock_init};
            pin_sync <= pin_meta;
            init_meta <= i_fuse_init;
            init_sync <= init_meta;
        end
    end

    assign {erase_s, fuse_wr_s, fuse_val_s, lock_init_s} = pin_sync;
    assign fuse_init_s = init_sync;

    ////////////////////////////////////////////////////////////////////////////////
    // controller state

    fsp_op_e op;
    logic [3:0] cmd;
    logic [2:0] age;
    logic [15:0] ptr;
    logic [5:0] locks;
    logic [5:0] fuses;
    logic [1:0] loaded;
    fsp_op_e next_op;
    logic [3:0] next_cmd;
    logic [2:0] next_age;
    logic [15:0] next_ptr;
    logic [5:0] next_locks;
    logic [5:0] next_fuses;
    logic [1:0] next_loaded;
    logic next_stall;
    logic next_load_valid;
    logic [7:0] next_load_data;
    logic next_load_deny;
    logic [7:0] next_rdata;
    logic next_flash_erase;
    logic [6:0] next_flash_page;
    logic next_prog_valid;
    logic buf_we;
    logic tmr_start;
    fsp_count_t tmr_len;
    logic readback;
    logic store_ok;

    // next-state logic of the whole controller
    always_comb begin
        next_op = op;
        next_cmd = cmd;
        next_age = age;
        next_ptr = ptr;
        next_locks = locks;
        next_fuses = fuses;
        next_loaded = loaded;
        next_stall = o_stall;
        next_load_valid = 1'b0;
        next_load_data = o_load_data;
        next_load_deny = 1'b0;
        next_rdata = 8'h00;
        next_flash_erase = 1'b0;
        next_flash_page = o_flash_page;
        buf_we = 1'b0;
        tmr_start = 1'b0;
        tmr_len = '0;
        readback = 1'b0;
        // nonvolatile values settle through the synchroniser before capture
        if (loaded != 2'h3) begin
            next_loaded = 2'(loaded + 2'h1);
            next_locks = lock_init_s;
            next_fuses = fuse_init_s;
        end else begin
            if (erase_s) begin
                next_locks = `FSP_LOCK_ERASED; // R22
            end
            // the core has no write path here; only the external pins reach fuses
            if (fuse_wr_s && (locks[`FSP_LK_RW] || erase_s)) begin
                next_fuses = fuse_val_s; // R2 R3
            end
        end
        // register reads
        if (i_io_rd) begin
            case (i_io_addr)
                `FSP_OFS_PTR_LOW: next_rdata = ptr[7:0];
                `FSP_OFS_PTR_HIGH: next_rdata = ptr[15:8];
                `FSP_OFS_CTRL: next_rdata = {4'h0, cmd};
                default: next_rdata = 8'h00;
            endcase
        end
        // register writes; control accepts only a legal code onto a clear register
        if (i_io_wr) begin
            case (i_io_addr)
                `FSP_OFS_PTR_LOW: next_ptr[7:0] = i_io_wdata;
                `FSP_OFS_PTR_HIGH: next_ptr[15:8] = i_io_wdata;
                `FSP_OFS_CTRL: begin
                    if (cmd == `FSP_CTRL_RESET && !i_eeprom_busy && is_legal(i_io_wdata[3:0])) begin
                        next_cmd = i_io_wdata[3:0]; // R17 R18
                        next_age = 3'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        // the window expires on the fourth cycle unless a store claims it
        if (cmd != `FSP_CTRL_RESET && op == FSP_OP_IDLE) begin
            if (age >= `FSP_WINDOW_STORE) begin
                next_cmd = `FSP_CTRL_RESET; // R15 R16
            end else begin
                next_age = 3'(age + 3'h1);
            end
        end
        // fuse and lock readback inside the shorter load window
        if (i_load_instr && cmd == `FSP_CMD_LOCK && age <= `FSP_WINDOW_LOAD &&
            op == FSP_OP_IDLE && !i_eeprom_busy) begin
            if (ptr[13:0] == `FSP_LOCK_READ_PTR) begin
                readback = 1'b1;
                next_load_data = {2'b11, locks}; // R19 R21
            end else if (ptr[13:0] == `FSP_FUSE_READ_PTR) begin
                readback = 1'b1;
                next_load_data = {2'b11, fuses}; // R20 R21
            end
            if (readback) begin
                next_load_valid = 1'b1;
                next_cmd = `FSP_CTRL_RESET; // R19
            end
        end
        // ordinary loads: only the boot pairs decide, ptr[0] is the byte select
        if (i_load_instr && !readback) begin
            next_load_deny = !read_ok(i_pc, ptr[13:1], locks); // R5 R13 R24
        end
        // stores are honoured only from boot code and with eeprom idle
        if (store_ok) begin
            case (cmd)
                `FSP_CMD_FILL: begin
                    buf_we = 1'b1; // R10
                    next_cmd = `FSP_CTRL_RESET; // R15
                end
                `FSP_CMD_ERASE: begin
                    if (write_ok(ptr[13:7], locks)) begin
                        next_cmd = cmd;
                        next_op = FSP_OP_ERASE; // R9
                        next_stall = 1'b1; // R7
                        next_flash_erase = 1'b1;
                        next_flash_page = ptr[13:7]; // R13
                        tmr_start = 1'b1; // R25
                        tmr_len = 11'(`FSP_ERASE_CYCLES);
                    end else begin
                        next_cmd = `FSP_CTRL_RESET; // R24
                    end
                end
                `FSP_CMD_WRITE: begin
                    if (write_ok(ptr[13:7], locks)) begin
                        next_cmd = cmd;
                        next_op = FSP_OP_WRITE; // R11
                        next_stall = 1'b1; // R7
                        next_flash_page = ptr[13:7];
                        tmr_start = 1'b1; // R25
                        tmr_len = 11'(`FSP_WRITE_CYCLES);
                    end else begin
                        next_cmd = `FSP_CTRL_RESET; // R24
                    end
                end
                `FSP_CMD_LOCK: begin
                    // pointer and high data are not looked at
                    next_locks[5:2] = next_locks[5:2] & i_data_low[5:2]; // R8 R14 R22
                    next_cmd = cmd;
                    next_op = FSP_OP_LOCK;
                    next_stall = 1'b1; // R8
                    tmr_start = 1'b1;
                    tmr_len = 11'(`FSP_LOCK_CYCLES);
                end
                default: begin
                end
            endcase
        end
        // completion releases the core and clears the command
        if (core_bus.tmr_done) begin
            next_op = FSP_OP_IDLE;
            next_cmd = `FSP_CTRL_RESET; // R7 R16
            next_stall = 1'b0; // R25
            if (op == FSP_OP_WRITE) begin
                next_ptr[13:0] = {7'(o_flash_page + 7'h01), 7'h00}; // R12
            end
        end
        // the whole page streams out during the first 64 timer cycles
        next_prog_valid = core_bus.tmr_busy && op == FSP_OP_WRITE &&
                          core_bus.tmr_count < 11'(`FSP_PAGE_WORDS); // R6
    end

    // R23 R4: boot code reaches any page, application code never stores
    assign store_ok = i_store_instr && cmd != `FSP_CTRL_RESET && op == FSP_OP_IDLE &&
                      in_boot(i_pc) && !i_eeprom_busy; // R23 R18

    assign core_bus.buf_we = buf_we;
    assign core_bus.buf_widx = ptr[6:1]; // R10 R13
    assign core_bus.buf_wdata = {i_data_high, i_data_low};
    assign core_bus.buf_ridx = core_bus.tmr_count[5:0];
    assign core_bus.tmr_start = tmr_start;
    assign core_bus.tmr_len = tmr_len;

    // register stage of the controller
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            op <= FSP_OP_IDLE;
            cmd <= `FSP_CTRL_RESET;
            age <= 3'h0;
            ptr <= 16'h0000;
            locks <= `FSP_LOCK_ERASED;
            fuses <= 6'h3F;
            loaded <= 2'h0;
            o_stall <= 1'b0;
            o_load_valid <= 1'b0;
            o_load_data <= 8'h00;
            o_load_deny <= 1'b0;
            o_io_rdata <= 8'h00;
            o_flash_erase <= 1'b0;
            o_flash_page <= 7'h00;
            o_flash_prog_valid <= 1'b0;
            o_flash_prog_addr <= 13'h0000;
            o_flash_prog_data <= 16'h0000;
            o_reset_vector <= `FSP_APP_VECTOR;
        end else begin
            op <= next_op;
            cmd <= next_cmd;
            age <= next_age;
            ptr <= next_ptr;
            locks <= next_locks;
            fuses <= next_fuses;
            loaded <= next_loaded;
            o_stall <= next_stall;
            o_load_valid <= next_load_valid;
            o_load_data <= next_load_data;
            o_load_deny <= next_load_deny;
            o_io_rdata <= next_rdata;
            o_flash_erase <= next_flash_erase;
            o_flash_page <= next_flash_page;
            o_flash_prog_valid <= next_prog_valid;
            o_flash_prog_addr <= {o_flash_page, core_bus.tmr_count[5:0]};
            o_flash_prog_data <= core_bus.buf_rdata;
            o_reset_vector <= fuses[`FSP_FUSE_BOOTVEC] ? `FSP_APP_VECTOR : `FSP_BOOT_START; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence seq_erase_start;
        store_ok && cmd == `FSP_CMD_ERASE && write_ok(ptr[13:7], locks);
    endsequence

    sequence seq_write_done;
        core_bus.tmr_done && op == FSP_OP_WRITE;
    endsequence

    AST_RESET_VECTOR: assert property (##1 o_reset_vector == ($past(fuses[0]) ? 13'h0000 : 13'h1E00)) // R1
        else $error("reset vector does not follow fuse");
    AST_FUSE_NO_CPU: assert property (loaded == 2'h3 && !fuse_wr_s |=> fuses == $past(fuses)) // R2
        else $error("fuse changed without external write");
    AST_FUSE_LOCKED: assert property (loaded == 2'h3 && !locks[0] && !erase_s |=> $stable(fuses)) // R3
        else $error("fuse changed while locked");
    AST_LOCK_ONE_WAY: assert property (loaded == 2'h3 && !erase_s |=> (locks & ~$past(locks)) == 6'h00) // R22
        else $error("lock bit returned to one without chip erase");
    AST_ERASE_STALL: assert property (seq_erase_start |=> o_stall [*8]) // R7
        else $error("core not stalled during erase");
    AST_PTR_NEXT_PAGE: assert property (seq_write_done |=> ptr[13:0] == {7'($past(o_flash_page) + 7'h01), 7'h00}) // R12
        else $error("pointer not at next page after write");
    AST_WINDOW_EXPIRE: assert property (cmd != 4'h0 && op == FSP_OP_IDLE && age == 3'h4 && !store_ok && !readback |=> cmd == 4'h0) // R15
        else $error("window did not expire after four cycles");
    AST_ILLEGAL_CODE: assert property (i_io_wr && i_io_addr == 6'h37 && cmd == 4'h0 && !is_legal(i_io_wdata[3:0]) |=> cmd == 4'h0) // R17
        else $error("illegal control code accepted");
    AST_EEPROM_BLOCK: assert property (i_io_wr && i_io_addr == 6'h37 && cmd == 4'h0 && i_eeprom_busy |=> cmd == 4'h0) // R18
        else $error("control write accepted during eeprom write");
    AST_APP_STORE: assert property (i_store_instr && i_pc < 13'h1E00 && op == FSP_OP_IDLE && !o_stall |=> !o_stall) // R23
        else $error("store from application section took effect");
    AST_LOCK_READ: assert property (i_load_instr && cmd == 4'h9 && age <= 3'h3 && op == FSP_OP_IDLE && !i_eeprom_busy && ptr[13:0] == 14'h0001 |=> o_load_valid && o_load_data == {2'b11, $past(locks)}) // R19
        else $error("lock readback wrong");
endmodule : fsp_flash_self_program
`default_nettype wire

/* File: testbench/fsp_core_model.sv */
// processor core model: register bus accesses and program-memory instructions
`default_nettype none
module fsp_core_model (
    // clock and read data
    input wire logic i_core_clk,
    input wire logic [7:0] i_rdata,
    // register bus and instruction strobes
    output logic [5:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    output logic o_st,
    output logic o_ld
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet bus at time zero
    initial begin
        {o_addr, o_wr, o_rd, o_wdata, o_st, o_ld} = '0;
    end
    // one write strobe, data inverted after
    task automatic wr_reg(input logic [5:0] ad, input logic [7:0] d);
        @(posedge i_core_clk);
        o_addr <= ad;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr_reg
    // answer stands the cycle after the strobe
    task automatic rd_reg(input logic [5:0] ad, output logic [7:0] q);
        @(posedge i_core_clk);
        o_addr <= ad;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        #1 q = i_rdata;
    endtask : rd_reg
    // store or load strobe, one cycle
    task automatic instr(input logic load);
        @(posedge i_core_clk);
        o_st <= ~load;
        o_ld <= load;
        @(posedge i_core_clk);
        o_st <= 1'b0;
        o_ld <= 1'b0;
    endtask : instr
endmodule : fsp_core_model
`default_nettype wire

/* File: testbench/fsp_flash_self_program_tb.sv */
// bench for the flash self-programming controller
`default_nettype none
module fsp_flash_self_program_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, busy, ce, fw;
    logic [12:0] pc;
    logic [7:0] dl, dh;
    logic [5:0] a;
    logic wr, rd, st, ld, stall, pv, ers, lv, dn;
    logic [7:0] wd, rdt, ldat, q, ldq;
    logic [12:0] rv, paddr;
    logic [15:0] pdat;
    logic [15:0] mem [64];
    logic [6:0] pg, fpg, epg;
    int n_fail = 0, cmp_count = 0, nw = 0, ne = 0;
    always #10 clk = ~clk;
    fsp_flash_self_program dut (.i_core_clk(clk), .i_nrst(nrst), .i_io_addr(a), .i_io_wr(wr),
        .i_io_rd(rd), .i_io_wdata(wd), .o_io_rdata(rdt), .i_store_instr(st), .i_load_instr(ld),
        .i_pc(pc), .i_data_low(dl), .i_data_high(dh), .i_eeprom_busy(busy), .o_stall(stall),
        .o_load_valid(lv), .o_load_data(ldat), .o_load_deny(dn), .o_reset_vector(rv),
        .o_flash_erase(ers), .o_flash_page(fpg), .o_flash_prog_valid(pv),
        .o_flash_prog_addr(paddr), .o_flash_prog_data(pdat), .i_lock_init(6'h3F),
        .i_fuse_init(6'h3E), .i_chip_erase(ce), .i_ext_fuse_wr(fw), .i_ext_fuse_val(6'h3F));
    fsp_core_model core (.i_core_clk(clk), .i_rdata(rdt), .o_addr(a), .o_wr(wr), .o_rd(rd),
        .o_wdata(wd), .o_st(st), .o_ld(ld));
    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    // halted operation: stall next cycle, then control reads zero
    task automatic run_op();
        core.instr(1'b0);
        #1 chk(16'(stall), 16'h1);
        for (int i = 0; i < 1100 && stall !== 1'b0; i++) @(posedge clk);
        core.rd_reg(6'h37, q);
        chk(16'(q), 16'h0);
    endtask : run_op
    // flash-side and readback monitors
    always @(posedge clk) begin
        if (pv === 1'b1) begin
            nw++;
            chk(pdat, mem[paddr[5:0]]);
            chk(16'(paddr[12:6]), 16'(pg));
        end
        if (ers === 1'b1) begin
            ne++;
            epg = fpg;
        end
        if (lv === 1'b1) ldq = ldat;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("Error %0t: watchdog", $time);
        wrap_up();
    end
    initial begin
        {busy, ce, fw, dl, dh, pc} <= 32'h1E10;
        void'($urandom(27));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        chk(16'(rv), 16'h1E00);
        core.rd_reg(6'h37, q);
        chk(16'(q), 16'h0);
        $display("reset test done");
        pg = 7'($urandom_range(111));
        // fill in descending order
        for (int i = 63; i >= 0; i--) begin
            mem[i] = 16'($urandom);
            core.wr_reg(6'h1F, {2'($urandom), pg[6:1]});
            core.wr_reg(6'h1E, {pg[0], 6'(i), 1'b0});
            {dh, dl} <= mem[i];
            core.wr_reg(6'h37, 8'h01);
            core.instr(1'b0);
        end
        core.wr_reg(6'h1E, {pg[0], 7'h00});
        core.wr_reg(6'h37, 8'h03);
        run_op();
        chk(16'(epg), 16'(pg));
        core.wr_reg(6'h37, 8'h05);
        run_op();
        chk(16'(nw), 16'd64);
        core.rd_reg(6'h1E, q);
        chk(16'(q), 16'({pg[0] ^ 1'b1, 7'h00}));
        core.rd_reg(6'h1F, q);
        chk(16'(q[5:0]), 16'((pg + 7'h01) >> 1));
        $display("page test done");
        busy <= 1'b1;
        core.wr_reg(6'h37, 8'h01);
        core.rd_reg(6'h37, q);
        chk(16'(q), 16'h0);
        busy <= 1'b0;
        core.wr_reg(6'h37, 8'h07);
        core.rd_reg(6'h37, q);
        chk(16'(q), 16'h0);
        core.wr_reg(6'h37, 8'h01);
        repeat (5) @(posedge clk);
        core.rd_reg(6'h37, q);
        chk(16'(q), 16'h0);
        ne = 0;
        pc <= 13'h0100;
        core.wr_reg(6'h37, 8'h03);
        core.instr(1'b0);
        repeat (6) @(posedge clk);
        chk(16'(ne), 16'h0);
        pc <= 13'h1E10;
        $display("refusal test done");
        dl <= 8'hDB;
        core.wr_reg(6'h37, 8'h09);
        run_op();
        core.wr_reg(6'h1F, 8'hC0);
        for (int k = 1; k >= 0; k--) begin
            core.wr_reg(6'h1E, 8'(k));
            core.wr_reg(6'h37, 8'h09);
            core.instr(1'b1);
            repeat (2) @(posedge clk);
            chk(16'(ldq), k ? 16'h00DB : 16'h00FE);
        end
        pc <= 13'h0100;
        core.wr_reg(6'h1F, 8'h3C);
        core.instr(1'b1);
        #1 chk(16'(dn), 16'h1);
        {ce, fw} <= 2'h3;
        repeat (6) @(posedge clk);
        core.instr(1'b1);
        #1 chk(16'(dn), 16'h0);
        chk(16'(rv), 16'h0);
        $display("lock test done");
        wrap_up();
    end
endmodule : fsp_flash_self_program_tb
`default_nettype wire
